// File: hsc_params.svh
// Offsets, codes, reset values and timing counts for the hot swap controller
`ifndef HSC_PARAMS_SVH
`define HSC_PARAMS_SVH
`define HSC_A_CMD 8'h00
`define HSC_A_PEC 8'h04
`define HSC_A_RES 8'h08
`define HSC_A_STW 8'h0C
`define HSC_A_STD 8'h10
`define HSC_A_CFG 8'h14
`define HSC_A_ALR 8'h18
`define HSC_A_MON 8'h1C
`define HSC_A_CAP 8'h20
`define HSC_A_IDS 8'h24
`define HSC_C_OP 8'h01
`define HSC_C_CLR 8'h03
`define HSC_C_ID 8'h99
`define HSC_C_MODEL 8'h9A
`define HSC_C_REV 8'h9B
`define HSC_C_ALR 8'hD0
`define HSC_C_MCFG 8'hD1
`define HSC_C_MCTL 8'hD2
`define HSC_C_DCFG 8'hD3
`define HSC_C_PCYC 8'hD9
`define HSC_ON_BIT 7
`define HSC_OP_RST 8'h80
`define HSC_DCFG_RST 8'h00
`define HSC_ALR_RST 16'h0000
`define HSC_MCFG_RST 8'h00
`define HSC_CAP_VAL 8'hB0
`define HSC_ID_LEN 3'h4
`define HSC_CRC_POLY 8'h07
`define HSC_SYNC_RST 7'h60
`define HSC_PC_TIME_MS 4000
`define HSC_CLK_KHZ 100000
`define HSC_PC_CYCLES (`HSC_PC_TIME_MS * `HSC_CLK_KHZ)
`endif

// File: hsc_pkg.sv
// Types shared by the hot swap command controller
package hsc_pkg;
   typedef enum logic [1:0] {MP_GPO, MP_ALERT, MP_CMP} hsc_mp_mode_t;
   typedef enum logic [1:0] {MON_IDLE, MON_SINGLE, MON_CONT} hsc_mon_st_t;
   typedef struct packed {
      logic pec_on;
      logic group;
      logic [15:0] data;
      logic [7:0] code;
   } hsc_cmd_t;
   typedef struct packed {
      hsc_mp_mode_t mode;
      logic gpo_level;
      logic [2:0] rsvd;
      logic [9:0] mask;
   } hsc_alert_cfg_t;
   typedef struct packed {
      logic [1:0] rsvd;
      logic [2:0] avg;
      logic range;
      logic outv_en;
      logic cont;
   } hsc_mon_cfg_t;
   typedef struct packed {
      logic op_en;
      logic [2:0] rsvd;
      logic warn2_under;
      logic [1:0] glitch;
      logic foldback;
   } hsc_dev_cfg_t;
endpackage

// File: hsc_ctrl.sv
// Command, status and gate control behind the hot swap management bus
`timescale 1ns/100ps
`include "hsc_params.svh"
// Notes on behaviour
// - No gate turn-on while undervoltage input low
// - Software off holds gate low always
// - On bit resets to one
// - Operation command refused until enabled
// - Operation enable comes from configuration command
// - Clearing on bit turns gate off
// - On request stored, but gate held off under UV or OV
// - Config holds foldback, glitch, warning polarity
// - Power cycle: off four seconds, on
// - Identity strings read with count first
// - Capability reports speed, check byte, alert
// - Five status registers in a hierarchy
// - Faults: overcurrent timeout, overvoltage, undervoltage
// - Warnings from monitor never touch gate
// - Fault and warning bits latch until cleared
// - Clear re-sets bits whose condition persists
// - Multipurpose pin: output, alert, comparator
// - Comparator mode follows threshold comparison
// - Masks ignored in software output mode
// - Monitor settings: mode, sampling, range, averaging
// - Monitor starts by trigger or command
// - Bad check byte: no execution, flag
// - Group command waits for stop condition
module hsc_ctrl #(
   parameter int unsigned PC_CYCLES = `HSC_PC_CYCLES,
   parameter logic [31:0] ID_STR = 32'h564E_4452, // Arbitrary value
   parameter logic [31:0] MODEL_STR = 32'h4D44_4C31, // Arbitrary value
   parameter logic [31:0] REV_STR = 32'h5245_5631 // Arbitrary value
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial bus lines, watched for the stop condition
   input wire logic scl_in,
   input wire logic sda_in,
   // Hot swap pins
   input wire logic undervolt_sense_in,
   input wire logic overvolt_sense_in,
   input wire logic oc_timeout_in,
   input wire logic supply_lockout,
   output logic fet_drive,
   output logic foldback_en,
   output logic [1:0] glitch_sel,
   output logic warn2_under,
   // Power monitor
   input wire logic hw_trigger_in,
   input wire logic conv_done,
   input wire logic [6:0] warn_in,
   input wire logic [6:0] cmp_in,
   output logic monitor_start,
   output logic monitor_running,
   output logic outv_sample_en,
   output hsc_pkg::hsc_mon_cfg_t mon_cfg,
   // Multipurpose pin
   output logic multipurpose_out_pin
);

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   function automatic logic [7:0] crc8(input logic [7:0] c,
                                       input logic [7:0] b);
      logic [7:0] r;
      r = c ^ b;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ({r[6:0], 1'b0} ^ `HSC_CRC_POLY) : {r[6:0], 1'b0};
      end
      return r;
   endfunction

   function automatic logic [7:0] id_byte(input logic [1:0] sel,
                                          input logic [2:0] idx);
      logic [31:0] s;
      s = (sel == 2'd0) ? ID_STR : (sel == 2'd1) ? MODEL_STR : REV_STR;
      return (idx == 3'd0) ? {5'd0, `HSC_ID_LEN} : s[8*(4-idx) +: 8];
   endfunction

   // Pin synchronisers
   logic [6:0] meta;
   logic [6:0] sync;
   logic scl_s, sda_s, uv_ok, ov_s, oc_s, lock_s, trig_s;
   logic sda_d, trig_d;
   assign {scl_s, sda_s, uv_ok, ov_s, oc_s, lock_s, trig_s} = sync;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta <= `HSC_SYNC_RST;
         sync <= `HSC_SYNC_RST;
         sda_d <= 1'b1;
         trig_d <= 1'b0;
      end else begin
         meta <= {scl_in, sda_in, undervolt_sense_in, overvolt_sense_in,
                  oc_timeout_in, supply_lockout, hw_trigger_in};
         sync <= meta;
         sda_d <= sda_s;
         trig_d <= trig_s;
      end
   end

   logic stop_det;
   assign stop_det = scl_s & sda_s & !sda_d;

   // APB: one wait state, so prdata can come from a flop
   logic apb_done, wr_en, rd_en;
   logic [31:0] next_prdata;
   logic addr_ok;
   assign apb_done = psel & penable & pready;
   assign wr_en = apb_done & pwrite;
   assign rd_en = apb_done & !pwrite;
   assign addr_ok = (paddr[1:0] == 2'b00) && (paddr <= `HSC_A_IDS);

   logic [7:0] pec_reg;
   logic res_nack, res_pec;
   logic [7:0] op_reg;
   hsc_pkg::hsc_dev_cfg_t dev_cfg;
   hsc_pkg::hsc_alert_cfg_t alert_cfg;
   hsc_pkg::hsc_mon_st_t mon_st;
   logic [9:0] cond, latch;
   logic [7:0] st_in, st_out, st_iout, st_vnd;
   logic [15:0] st_word;
   logic pc_active;
   logic [1:0] id_sel;
   logic [2:0] id_idx;
   logic pend_v, stop_seen;

   always_comb begin
      next_prdata = 32'h0000_0000;
      case (paddr)
         `HSC_A_PEC: next_prdata = {24'h00_0000, pec_reg};
         `HSC_A_RES: next_prdata = {28'h000_0000, pc_active, pend_v,
                                    res_pec, res_nack};
         `HSC_A_STW: next_prdata = {16'h0000, st_word};
         `HSC_A_STD: next_prdata = {st_vnd, st_iout, st_out, st_in};
         `HSC_A_CFG: next_prdata = {16'h0000, dev_cfg, op_reg};
         `HSC_A_ALR: next_prdata = {16'h0000, alert_cfg};
         `HSC_A_MON: next_prdata = {23'h00_0000, monitor_running, mon_cfg};
         `HSC_A_CAP: next_prdata = {24'h00_0000, `HSC_CAP_VAL};
         `HSC_A_IDS: next_prdata = (id_idx <= `HSC_ID_LEN) ?
            {24'h00_0000, id_byte(id_sel, id_idx)} : 32'h0000_0000;
         default: next_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & !pready;
         if (psel & penable & !pready) begin
            pslverr <= !addr_ok;
            prdata <= pwrite ? 32'h0000_0000 : next_prdata;
         end
      end
   end

   // Command intake and check byte
   hsc_pkg::hsc_cmd_t new_cmd, pend_cmd, exec_cmd;
   logic cmd_wr, pec_ok, op_lock, acc, exec_v;
   logic [7:0] pec_exp;
   assign new_cmd = hsc_pkg::hsc_cmd_t'(pwdata[25:0]);
   assign cmd_wr = wr_en && (paddr == `HSC_A_CMD);
   assign pec_exp = (new_cmd.code == `HSC_C_ALR) ?
      crc8(crc8(crc8(8'h00, new_cmd.code), new_cmd.data[7:0]),
           new_cmd.data[15:8]) :
      crc8(crc8(8'h00, new_cmd.code), new_cmd.data[7:0]);
   assign pec_ok = !new_cmd.pec_on || (pec_exp == pec_reg);
   assign op_lock = (new_cmd.code == `HSC_C_OP) && !dev_cfg.op_en;
   assign acc = cmd_wr && pec_ok && !op_lock;

   logic clr_pulse;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pec_reg <= 8'h00;
         res_nack <= 1'b0;
         res_pec <= 1'b0;
      end else begin
         if (wr_en && paddr == `HSC_A_PEC) begin
            pec_reg <= pwdata[7:0];
         end
         // A refusal in the clear cycle still sets its flag
         res_nack <= (res_nack & !clr_pulse) | (cmd_wr & pec_ok & op_lock);
         res_pec <= (res_pec & !clr_pulse) | (cmd_wr & !pec_ok);
      end
   end

   // Group commands wait for a stop; an immediate one in that cycle goes first
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         exec_v <= 1'b0;
         exec_cmd <= '0;
         pend_v <= 1'b0;
         pend_cmd <= '0;
         stop_seen <= 1'b0;
      end else begin
         exec_v <= 1'b0;
         if (acc && !new_cmd.group) begin
            exec_v <= 1'b1;
            exec_cmd <= new_cmd;
            if (pend_v && stop_det) begin
               stop_seen <= 1'b1;
            end
         end else if (pend_v && stop_seen) begin
            exec_v <= 1'b1;
            exec_cmd <= pend_cmd;
            pend_v <= 1'b0;
            stop_seen <= 1'b0;
         end else if (pend_v && stop_det) begin
            stop_seen <= 1'b1;
         end
         if (acc && new_cmd.group) begin
            pend_v <= 1'b1;
            pend_cmd <= new_cmd;
            stop_seen <= 1'b0;
         end
      end
   end

   logic ex_op, ex_clr, ex_pcyc;
   assign ex_op = exec_v && exec_cmd.code == `HSC_C_OP;
   assign ex_clr = exec_v && exec_cmd.code == `HSC_C_CLR;
   assign ex_pcyc = exec_v && exec_cmd.code == `HSC_C_PCYC;

   // Settings written by commands
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         op_reg <= `HSC_OP_RST;
         dev_cfg <= `HSC_DCFG_RST;
         alert_cfg <= `HSC_ALR_RST;
         mon_cfg <= `HSC_MCFG_RST;
         clr_pulse <= 1'b0;
      end else begin
         clr_pulse <= ex_clr || (ex_op && !op_reg[`HSC_ON_BIT] &&
                      exec_cmd.data[`HSC_ON_BIT]);
         if (ex_op) begin
            op_reg <= exec_cmd.data[7:0];
         end
         if (exec_v && exec_cmd.code == `HSC_C_DCFG) begin
            dev_cfg <= exec_cmd.data[7:0];
         end
         if (exec_v && exec_cmd.code == `HSC_C_ALR) begin
            alert_cfg <= exec_cmd.data;
         end
         // Changing these while sampling is the host's risk
         if (exec_v && exec_cmd.code == `HSC_C_MCFG) begin
            mon_cfg <= exec_cmd.data[7:0];
         end
         if (lock_s) begin
            op_reg <= `HSC_OP_RST;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         foldback_en <= 1'b0;
         glitch_sel <= 2'b00;
         warn2_under <= 1'b0;
      end else begin
         foldback_en <= dev_cfg.foldback;
         glitch_sel <= dev_cfg.glitch;
         warn2_under <= dev_cfg.warn2_under;
      end
   end

   // Power cycle timer
   logic [31:0] pc_cnt;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pc_active <= 1'b0;
         pc_cnt <= 32'h0000_0000;
      end else if (ex_pcyc) begin
         pc_active <= 1'b1;
         pc_cnt <= PC_CYCLES - 32'd1;
      end else if (pc_active) begin
         pc_cnt <= pc_cnt - 32'd1;
         if (pc_cnt == 32'h0000_0000) begin
            pc_active <= 1'b0;
         end
      end
   end

   // Gate: warnings are deliberately not in this term
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         fet_drive <= 1'b0;
      end else begin
         fet_drive <= op_reg[`HSC_ON_BIT] & uv_ok & !ov_s & !oc_s &
                      !pc_active & !lock_s;
      end
   end

   // Status: faults then warnings, set wins over clear
   assign cond = {oc_s, !uv_ok, ov_s, warn_in};
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latch <= 10'h000;
      end else begin
         latch <= (latch & ~{10{clr_pulse}}) | cond;
      end
   end

   assign st_in = {latch[7], latch[6], latch[5], latch[8], 4'h0};
   assign st_out = {1'b0, latch[4], latch[3], 5'h00};
   assign st_iout = {latch[9], 1'b0, latch[2], 5'h00};
   assign st_vnd = {6'h00, latch[0], latch[1]};
   assign st_word = {|st_out, |st_iout, |st_in, |st_vnd, 4'h0,
                     1'b0, !fet_drive, 1'b0, latch[9], latch[8], 1'b0,
                     res_nack | res_pec, latch[7]};

   // Identity stream: count byte, then characters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         id_sel <= 2'd0;
         id_idx <= 3'd0;
      end else if (exec_v && (exec_cmd.code == `HSC_C_ID ||
                   exec_cmd.code == `HSC_C_MODEL ||
                   exec_cmd.code == `HSC_C_REV)) begin
         id_sel <= exec_cmd.code[1:0] - 2'd1;
         id_idx <= 3'd0;
      end else if (rd_en && paddr == `HSC_A_IDS && id_idx <= `HSC_ID_LEN) begin
         id_idx <= id_idx + 3'd1;
      end
   end

   // Multipurpose pin; alert is active low
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         multipurpose_out_pin <= 1'b1;
      end else begin
         case (alert_cfg.mode)
            hsc_pkg::MP_GPO: multipurpose_out_pin <= alert_cfg.gpo_level;
            hsc_pkg::MP_ALERT:
               multipurpose_out_pin <= !(|(latch & alert_cfg.mask));
            hsc_pkg::MP_CMP:
               multipurpose_out_pin <= |(cmp_in & alert_cfg.mask[6:0]);
            default: multipurpose_out_pin <= 1'b1;
         endcase
      end
   end

   // Power monitor sequencing
   logic mon_go, mon_stop;
   assign mon_go = (exec_v && exec_cmd.code == `HSC_C_MCTL &&
                    exec_cmd.data[0]) || (trig_s && !trig_d);
   assign mon_stop = exec_v && exec_cmd.code == `HSC_C_MCTL &&
                     !exec_cmd.data[0];
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mon_st <= hsc_pkg::MON_IDLE;
         monitor_start <= 1'b0;
         monitor_running <= 1'b0;
         outv_sample_en <= 1'b0;
      end else begin
         monitor_start <= 1'b0;
         case (mon_st)
            hsc_pkg::MON_IDLE: begin
               if (mon_go) begin
                  mon_st <= mon_cfg.cont ? hsc_pkg::MON_CONT :
                                           hsc_pkg::MON_SINGLE;
                  monitor_start <= 1'b1;
               end
            end
            hsc_pkg::MON_SINGLE: begin
               if (conv_done || mon_stop) begin
                  mon_st <= hsc_pkg::MON_IDLE;
               end
            end
            hsc_pkg::MON_CONT: begin
               if (mon_stop) begin
                  mon_st <= hsc_pkg::MON_IDLE;
               end else if (conv_done) begin
                  monitor_start <= 1'b1;
               end
            end
            default: mon_st <= hsc_pkg::MON_IDLE;
         endcase
         monitor_running <= mon_st != hsc_pkg::MON_IDLE;
         outv_sample_en <= (mon_st != hsc_pkg::MON_IDLE) &&
                           mon_cfg.outv_en;
      end
   end

   a_uv_blocks_gate: assert property (!uv_ok |=> !fet_drive)
      else $error("gate on while undervoltage low");
   a_off_holds_low: assert property (!op_reg[7] |=> !fet_drive)
      else $error("gate on while software off");
   a_lock_sets_on: assert property (lock_s |=> op_reg[7])
      else $error("on bit not restored");
   a_op_nack_lock: assert property (cmd_wr && pec_ok &&
      new_cmd.code == `HSC_C_OP && !dev_cfg.op_en |=> res_nack && !exec_v)
      else $error("locked operation not refused");
   a_op_takes_data: assert property (ex_op && !lock_s |=>
      op_reg == $past(exec_cmd.data[7:0]))
      else $error("operation data not applied");
   a_on_clear_off: assert property (ex_op && !exec_cmd.data[7]
      |-> ##2 !fet_drive) else $error("gate stays on after off");
   a_ov_blocks_gate: assert property (ov_s |=> !fet_drive)
      else $error("gate on under overvoltage");
   a_toggle_clears: assert property (ex_op && exec_cmd.data[7] &&
      !op_reg[7] |=> clr_pulse ##1 latch == $past(cond))
      else $error("toggle did not clear");
   a_pcycle_off: assert property (ex_pcyc |-> ##2 !fet_drive [*8])
      else $error("gate on during power cycle");
   a_status_latch: assert property (|cond |=>
      (latch & $past(cond)) == $past(cond)) else $error("bit not latched");
   a_gpo_mode: assert property (alert_cfg.mode == hsc_pkg::MP_GPO &&
      $stable(alert_cfg) |=> multipurpose_out_pin == $past(alert_cfg.gpo_level))
      else $error("pin not under software");
   a_pec_reject: assert property (cmd_wr && !pec_ok |=> res_pec &&
      !exec_v) else $error("bad check byte executed");
   a_group_hold: assert property (pend_v && !stop_seen &&
      !(acc && !new_cmd.group) |=> !exec_v)
      else $error("group executed before stop");

   c_gate_on: cover property (!fet_drive ##1 fet_drive);
   c_group_exec: cover property (pend_v && stop_seen ##1 exec_v);
   c_pcycle: cover property (ex_pcyc);
   c_pec_bad: cover property (cmd_wr && !pec_ok);

endmodule // hsc_ctrl

// File: hsc_host_model.sv
// Bus master model: frames on the serial lines, each closed by a stop
`timescale 1ns/100ps
module hsc_host_model (
   // Frame request from the bench
   input wire logic go,
   // Serial lines, pulled up while released
   output logic scl,
   output logic sda
);
   // Clock stands still outside frames; data moves while clock is low, except at start and stop
   // Edges sit 3 ns off the block's clock so sampling is not a race
   initial begin
      scl = 1'b1;
      sda = 1'b1;
      forever begin
         @(posedge go);
         #3 sda = 1'b0;
         #40 scl = 1'b0;
         repeat (9) begin
            #20 sda = ~sda;
            #20 scl = 1'b1;
            #40 scl = 1'b0;
         end
         #20 sda = 1'b0;
         #20 scl = 1'b1;
         #40 sda = 1'b1; // Stop releases held group commands
      end
   end
endmodule // hsc_host_model

// File: hot_swap_pmbus_command_ctrl_test.sv
// Self-checking bench for the hot swap command controller
`timescale 1ns/100ps
`include "hsc_params.svh"
module hot_swap_pmbus_command_ctrl_test;
   localparam logic [31:0] S0 = 32'h4142_4344; // Arbitrary value
   localparam logic [31:0] S1 = 32'h4546_4748; // Arbitrary value
   localparam logic [31:0] S2 = 32'h494A_4B4C; // Arbitrary value
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, scl, sda, go;
   logic uv, ov, oc, lock, trig, done, fet, fb, w2, mst, mrun, oven, mp;
   logic seen, rerr;
   logic [1:0] gl;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rdat, str;
   logic [6:0] warn, cmpv;
   hsc_pkg::hsc_mon_cfg_t mcfg;
   int num_errors = 0;
   int checks = 0;

   hsc_ctrl #(.PC_CYCLES(50), .ID_STR(S0), .MODEL_STR(S1), .REV_STR(S2))
   uut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .scl_in(scl), .sda_in(sda),
      .undervolt_sense_in(uv), .overvolt_sense_in(ov),
      .oc_timeout_in(oc), .supply_lockout(lock), .fet_drive(fet),
      .foldback_en(fb), .glitch_sel(gl), .warn2_under(w2),
      .hw_trigger_in(trig), .conv_done(done), .warn_in(warn),
      .cmp_in(cmpv), .monitor_start(mst), .monitor_running(mrun),
      .outv_sample_en(oven), .mon_cfg(mcfg), .multipurpose_out_pin(mp));

   hsc_host_model host (.go(go), .scl(scl), .sda(sda));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Start pulses last one cycle, so keep a sticky copy
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         seen <= 1'b0;
      else if (mst === 1'b1)
         seen <= 1'b1;
   end

   task automatic end_of_test;
      $display("checks=%0d num_errors=%0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic chkb(input logic g, input logic e);
      chk({31'h0, g}, {31'h0, e});
   endtask

   // One transfer: setup, access, hold until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic settle;
      repeat (8) @(posedge clk);
   endtask

   task automatic cmd(input logic [7:0] c, input logic [15:0] v,
                      input logic g = 1'b0, input logic p = 1'b0);
      hsc_pkg::hsc_cmd_t k;
      k = '{pec_on: p, group: g, data: v, code: c};
      wr(`HSC_A_CMD, {6'h00, k});
      settle;
   endtask

   // Check byte over code then data low, most significant bit first
   function automatic logic [7:0] crc(input logic [7:0] c,
                                      input logic [7:0] v);
      logic [7:0] r;
      logic [15:0] s;
      r = 8'h00;
      s = {c, v};
      for (int i = 15; i >= 0; i--)
         r = {r[6:0], 1'b0} ^ ((r[7] ^ s[i]) ? 8'h07 : 8'h00);
      return r;
   endfunction

   initial begin
      #300000;
      num_errors++;
      end_of_test;
   end

   initial begin
      nrst = 1'b0;
      {psel, penable, pwrite, go, ov, oc, lock, trig, done} = '0;
      uv = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      warn = 7'h00;
      cmpv = 7'h00;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      settle;
      chkb(fet, 1'b1);
      rd(`HSC_A_CFG);
      chk(rdat, 32'h0000_0080);
      rd(`HSC_A_CAP);
      chk(rdat, 32'h0000_00B0);
      rd(8'h28);
      chk({rdat[30:0], rerr}, 32'h0000_0001);
      cmd(`HSC_C_OP, 16'h0000);
      chkb(fet, 1'b1);
      rd(`HSC_A_RES);
      chkb(rdat[0], 1'b1);
      cmd(`HSC_C_DCFG, 16'h008F); // Host enables the command first
      chk({28'h0, fb, gl, w2}, 32'h0000_000F);
      cmd(`HSC_C_OP, 16'h0000);
      chkb(fet, 1'b0);
      lock <= 1'b1;
      settle;
      chkb(fet, 1'b0);
      lock <= 1'b0;
      rd(`HSC_A_CFG);
      chk(rdat, 32'h0000_8F80);
      cmd(`HSC_C_OP, 16'h0000);
      uv <= 1'b0;
      settle;
      cmd(`HSC_C_OP, 16'h0080);
      chkb(fet, 1'b0);
      uv <= 1'b1;
      ov <= 1'b1;
      settle;
      chkb(fet, 1'b0);
      ov <= 1'b0;
      settle;
      chkb(fet, 1'b1);
      warn <= 7'h04;
      settle;
      warn <= 7'h00;
      settle;
      chkb(fet, 1'b1);
      rd(`HSC_A_STW);
      chk(rdat, 32'h0000_6009);
      rd(`HSC_A_STD);
      chk(rdat, 32'h0020_0090);
      oc <= 1'b1;
      uv <= 1'b0;
      settle;
      oc <= 1'b0;
      settle;
      cmd(`HSC_C_CLR, 16'h0000);
      rd(`HSC_A_STD);
      chk(rdat, 32'h0000_0010);
      uv <= 1'b1;
      settle;
      cmd(`HSC_C_OP, 16'h0000);
      cmd(`HSC_C_OP, 16'h0080);
      rd(`HSC_A_STW);
      chk({22'h0, rdat[9:0]}, 32'h0000_0000);
      warn <= 7'h04;
      settle;
      warn <= 7'h00;
      cmd(`HSC_C_ALR, 16'h23FF);
      chkb(mp, 1'b1);
      cmd(`HSC_C_ALR, 16'h4004);
      chkb(mp, 1'b0);
      cmd(`HSC_C_ALR, 16'h4008);
      chkb(mp, 1'b1);
      cmd(`HSC_C_ALR, 16'h8004);
      cmpv <= 7'h04;
      settle;
      chkb(mp, 1'b1);
      cmpv <= 7'h00;
      settle;
      chkb(mp, 1'b0);
      for (int k = 0; k < 3; k++) begin
         cmd(`HSC_C_ID + 8'(k), 16'h0000);
         rd(`HSC_A_IDS);
         chk(rdat, 32'h0000_0004);
         str = (k == 0) ? S0 : ((k == 1) ? S1 : S2);
         for (int j = 3; j >= 0; j--) begin
            rd(`HSC_A_IDS);
            chk(rdat, {24'h0, str[8*j +: 8]});
         end
      end
      wr(`HSC_A_PEC, {24'h0, crc(`HSC_C_DCFG, 8'h80)});
      cmd(`HSC_C_DCFG, 16'h0080, 1'b0, 1'b1);
      chk({28'h0, fb, gl, w2}, 32'h0000_0000);
      wr(`HSC_A_PEC, {24'h0, ~crc(`HSC_C_DCFG, 8'h81)});
      cmd(`HSC_C_DCFG, 16'h0081, 1'b0, 1'b1);
      chkb(fb, 1'b0);
      rd(`HSC_A_RES);
      chkb(rdat[1], 1'b1);
      cmd(`HSC_C_DCFG, 16'h0081, 1'b1);
      chkb(fb, 1'b0);
      rd(`HSC_A_RES);
      chkb(rdat[2], 1'b1);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (150) @(posedge clk);
      chkb(fb, 1'b1);
      cmd(`HSC_C_PCYC, 16'h0000);
      chkb(fet, 1'b0);
      repeat (60) @(posedge clk);
      chkb(fet, 1'b1);
      cmd(`HSC_C_MCFG, 16'h0003); // Monitor stopped while set up
      chk({24'h0, mcfg}, 32'h0000_0003);
      cmd(`HSC_C_MCTL, 16'h0001);
      chk({29'h0, seen, mrun, oven}, 32'h0000_0007);
      cmd(`HSC_C_MCTL, 16'h0000);
      chkb(mrun, 1'b0);
      cmd(`HSC_C_MCFG, 16'h0000);
      trig <= 1'b1;
      settle;
      trig <= 1'b0;
      chk({30'h0, mrun, oven}, 32'h0000_0002);
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      settle;
      chkb(mrun, 1'b0);
      end_of_test;
   end
endmodule // hot_swap_pmbus_command_ctrl_test
